// ==== bench/led_bank_sva.sv ====
// Purpose: Port-level checks for the LED driver register bank.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Sleep bit is tracked from writes, since it is not a port.
`timescale 1ns/1ps
`default_nettype none
module led_bank_sva
    import led_bank_pkg::*;
#(
    parameter int WAKE_COUNT = WAKE_CYCLES
) (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire reg_req_s   regReq,
    input wire logic       ptrValid,
    input wire logic [7:0] rdData,
    input wire logic [6:0] altAddr1,
    input wire logic [3:0] addrEnable,
    input wire logic [2:0] autoIncOpt,
    input wire logic       oscRunning
);
    // =====
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic        sleepFf;
    logic [15:0] awakeCnt;
    sequence wrModeOne;
        regReq.wr && regReq.ptr == OFS_MODE_ONE;
    endsequence
    sequence rdAt(logic [4:0] p);
        regReq.rd && regReq.ptr == p;
    endsequence
    // Mirror of the sleep bit; a wake counter bounds the start-up time.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sleepFf <= 1'b1;
        end else if (regReq.wr && regReq.ptr == OFS_MODE_ONE) begin
            sleepFf <= regReq.data[BIT_SLEEP];
        end
    end
    // Counts cycles spent awake but without a running oscillator.
    always_ff @(posedge mclk) begin
        if (!rst_n || sleepFf || oscRunning) begin
            awakeCnt <= 16'h0000;
        end else begin
            awakeCnt <= awakeCnt + 16'h0001;
        end
    end
    chk_ptr_ack: assert property (ptrValid == (regReq.ptr <= OFS_LAST_VALID))
        else $error("pointer acknowledge wrong");
    chk_rsvd_read: assert property (regReq.rd && regReq.ptr > 5'h11 |=> rdData == 8'h00)
        else $error("reserved pointer read not zero");
    chk_rsvd_write: assert property (regReq.wr && regReq.ptr > 5'h11 |=> $stable(addrEnable))
        else $error("reserved write changed state");
    chk_autoinc_ro: assert property (rdAt(OFS_MODE_ONE) |=> rdData[7:5] == 3'b100 && autoIncOpt == 3'b100)
        else $error("auto-increment bits wrong");
    chk_mode_control_two_zero: assert property (rdAt(OFS_MODE_TWO) |=> rdData[7:6] == 2'b00)
        else $error("mode two upper bits not zero");
    chk_addr_enable: assert property (wrModeOne |=> addrEnable == $past(regReq.data[3:0]))
        else $error("address enables not written");
    chk_reset_addr: assert property ($rose(rst_n) |-> addrEnable == 4'b0001 && altAddr1 == RST_ALT_ONE)
        else $error("address reset values wrong");
    chk_alt_write: assert property (regReq.wr && regReq.ptr == OFS_ALT_ONE |=> altAddr1 == $past(regReq.data[7:1]))
        else $error("alternate address not written at once");
    chk_sleep_stop: assert property (sleepFf |=> !oscRunning)
        else $error("oscillator runs in low power");
    chk_wake_bound: assert property (awakeCnt <= 16'(WAKE_COUNT + 2))
        else $error("oscillator wake took too long");
endmodule
bind led_driver_register_bank led_bank_sva #(.WAKE_COUNT(WAKE_COUNT)) chkInst (
    .mclk(mclk), .rst_n(rst_n), .regReq(regReq), .ptrValid(ptrValid), .rdData(rdData),
    .altAddr1(altAddr1), .addrEnable(addrEnable), .autoIncOpt(autoIncOpt),
    .oscRunning(oscRunning));
`default_nettype wire

// ==== bench/reg_master_model.sv ====
// Purpose: Register master standing in for the serial front end.
// Assumes: One byte access per strobe, changed at the falling edge.
// Notes:   Idle fields carry the inverse of the last value, never stale data.
`timescale 1ns/1ps
`default_nettype none
module reg_master_model
    import led_bank_pkg::*;
(
    input  wire logic [7:0] rdData,
    input  wire logic       mclk,
    output var reg_req_s    regReq,
    output var logic        busAck,
    output var logic        busStop
);
    // =====
    // Bus starts idle.
    initial begin
        regReq = '0;
        busAck = 1'b0;
        busStop = 1'b0;
    end
    // One strobe held across one rising edge; read data taken afterwards.
    task automatic access(input logic w, input logic [4:0] p, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge mclk);
        regReq = '{wr: w, rd: !w, ptr: p, data: d};
        @(negedge mclk);
        regReq = '{wr: 1'b0, rd: 1'b0, ptr: ~p, data: ~d};
        q = rdData;
    endtask
    // A one-cycle stop or acknowledge pulse.
    task automatic pulse(input logic stop);
        @(negedge mclk);
        busStop = stop;
        busAck = !stop;
        @(negedge mclk);
        busStop = 1'b0;
        busAck = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the LED driver register bank.
// Assumes: Short wake count; one PWM step per clock.
// Notes:   Duty is measured over two full PWM periods so phase does not matter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import led_bank_pkg::*;
    localparam int WAKE = 20;
    localparam logic [7:0] RSTV [18] = '{8'h91, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'he2, 8'he4, 8'he8, 8'he0};
    logic                mclk;
    logic                rst_n;
    reg_req_s            regReq;
    logic                busAck;
    logic                busStop;
    logic                ptrValid;
    logic [7:0]          rdData;
    logic [6:0]          altAddr1;
    logic [3:0]          addrEnable;
    logic                oscRunning;
    logic [7:0]          ledOn;
    logic [7:0]          q;
    int                  failures;
    int                  checks;
    int                  hi;
    led_driver_register_bank #(.WAKE_COUNT(WAKE)) dut (
        .mclk(mclk), .rst_n(rst_n), .regReq(regReq), .busAck(busAck),
        .busStop(busStop), .ptrValid(ptrValid), .rdData(rdData), .altAddr1(altAddr1),
        .altAddr2(), .altAddr3(), .bcastAddr(), .addrEnable(addrEnable),
        .autoIncOpt(), .oscRunning(oscRunning), .ledOn(ledOn));
    reg_master_model mst (.rdData(rdData), .mclk(mclk), .regReq(regReq),
        .busAck(busAck), .busStop(busStop));
    // =====
    // Compare and count; a mismatch is reported at once.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] p, input logic [7:0] d);
        mst.access(1'b1, p, d, q);
    endtask
    task automatic rd(input logic [4:0] p, input logic [7:0] exp);
        mst.access(1'b0, p, 8'h00, q);
        chk(q, exp);
    endtask
    // Counts high samples of output 0 over two PWM periods.
    task automatic duty(input int exp);
        hi = 0;
        repeat (512 * PWM_TICK_DIV) @(negedge mclk) if (ledOn[0] === 1'b1) hi++;
        chk(16'(hi), 16'(exp * PWM_TICK_DIV));
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Free-running clock at 40 MHz.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Watchdog: the tests need a few thousand cycles.
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        final_report();
    end
    // Main sequence.
    initial begin
        failures = 0;
        checks = 0;
        rst_n = 1'b0;
        repeat (12) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        for (int i = 0; i < 18; i++) rd(5'(i), RSTV[i]);
        for (int i = 18; i < 32; i++) begin
            wr(5'(i), 8'h5a);
            rd(5'(i), 8'h00);
        end
        rd(OFS_MODE_ONE, 8'h91);
        for (int i = 2; i < 18; i++) wr(5'(i), 8'(i + 16));
        chk(altAddr1, 7'h0f);
        for (int i = 2; i < 18; i++) rd(5'(i), 8'(i + 16) & (i > 13 ? 8'hfe : 8'hff));
        // Master keeps the reserved mode two bits and clears low power.
        wr(OFS_MODE_TWO, 8'hc5);
        rd(OFS_MODE_TWO, 8'h05);
        wr(OFS_MODE_ONE, 8'hef);
        rd(OFS_MODE_ONE, 8'h8f);
        chk(addrEnable, 4'hf);
        hi = 0;
        while (oscRunning !== 1'b1 && hi < 100) @(negedge mclk) hi++;
        chk(16'(hi >= WAKE - 6 && hi <= WAKE + 2), 16'h0001);
        wr(OFS_STATE_LOW, 8'h00);
        wr(OFS_STATE_HIGH, 8'h00);
        mst.pulse(1'b1);
        chk(ledOn, 8'h00);
        wr(OFS_STATE_LOW, 8'h01);
        chk(ledOn, 8'h00);
        mst.pulse(1'b1);
        chk(ledOn, 8'h01);
        wr(OFS_MODE_TWO, 8'h0d);
        wr(OFS_STATE_LOW, 8'h04);
        chk(ledOn, 8'h01);
        mst.pulse(1'b0);
        chk(ledOn, 8'h02);
        wr(OFS_MODE_TWO, 8'h05);
        wr(OFS_STATE_LOW, 8'h02);
        foreach (RSTV[k]) if (k < 3) begin
            wr(OFS_DUTY_FIRST, k == 0 ? 8'h00 : (k == 1 ? 8'h40 : 8'hff));
            mst.pulse(1'b1);
            duty(k == 0 ? 0 : (k == 1 ? 128 : 510));
        end
        // Group duty of zero must blank a state-11 output in both group modes.
        wr(OFS_GROUP_DUTY, 8'h00);
        wr(OFS_STATE_LOW, 8'h03);
        mst.pulse(1'b1);
        duty(0);
        wr(OFS_MODE_TWO, 8'h25);
        rd(OFS_MODE_TWO, 8'h25);
        duty(0);
        wr(OFS_MODE_ONE, 8'h11);
        duty(0);
        chk(oscRunning, 1'b0);
        // Second reset in mid-run restores the duty registers.
        @(negedge mclk) rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        rd(OFS_DUTY_FIRST, 8'h00);
        final_report();
    end
endmodule
`default_nettype wire

// ==== hdl/led_bank_pkg.sv ====
// Purpose: Shared constants and types for the LED driver register bank.
// Assumes: Registers are reached through a byte-wide access port from an I2C slave front end.
// Notes:   Offsets are register pointer values; all registers are 8 bits wide.
package led_bank_pkg;
    // ========================================
    // Register pointers
    localparam logic [4:0] OFS_MODE_ONE     = 5'h00;
    localparam logic [4:0] OFS_MODE_TWO     = 5'h01;
    localparam logic [4:0] OFS_DUTY_FIRST   = 5'h02;
    localparam logic [4:0] OFS_DUTY_LAST    = 5'h09;
    localparam logic [4:0] OFS_GROUP_DUTY   = 5'h0a;
    localparam logic [4:0] OFS_GROUP_PERIOD = 5'h0b;
    localparam logic [4:0] OFS_STATE_LOW    = 5'h0c;
    localparam logic [4:0] OFS_STATE_HIGH   = 5'h0d;
    localparam logic [4:0] OFS_ALT_ONE      = 5'h0e;
    localparam logic [4:0] OFS_ALT_TWO      = 5'h0f;
    localparam logic [4:0] OFS_ALT_THREE    = 5'h10;
    localparam logic [4:0] OFS_BROADCAST    = 5'h11;
    localparam logic [4:0] OFS_LAST_VALID   = 5'h11;
    // ========================================
    // Field positions
    localparam int BIT_SLEEP     = 4;
    localparam int BIT_ALT1_EN   = 3;
    localparam int BIT_ALT2_EN   = 2;
    localparam int BIT_ALT3_EN   = 1;
    localparam int BIT_BCAST_EN  = 0;
    localparam int BIT_GROUP_FN  = 5;
    localparam int BIT_UPD_TIME  = 3;
    // ========================================
    // Reset values
    localparam logic [2:0] RST_AUTOINC      = 3'h4;
    localparam logic [4:0] RST_MODE_ONE_LO  = 5'h11;
    localparam logic [5:0] RST_MODE_TWO_LO  = 6'h05;
    localparam logic [7:0] RST_DUTY         = 8'h00;
    localparam logic [7:0] RST_GROUP_DUTY   = 8'hff;
    localparam logic [7:0] RST_GROUP_PERIOD = 8'h00;
    localparam logic [7:0] RST_STATE        = 8'h00;
    localparam logic [6:0] RST_ALT_ONE      = 7'h71;
    localparam logic [6:0] RST_ALT_TWO      = 7'h72;
    localparam logic [6:0] RST_ALT_THREE    = 7'h74;
    localparam logic [6:0] RST_BROADCAST    = 7'h70;
    // ========================================
    // Timing
    localparam int  CLK_HZ          = 40_000_000;
    localparam int  WAKE_US         = 500;
    localparam int  WAKE_CYCLES     = (CLK_HZ / 1_000_000) * WAKE_US;
    localparam int  PWM_HZ          = 97_000;
    localparam int  PWM_TICK_DIV    = CLK_HZ / (PWM_HZ * 256);
    localparam int  DIM_HZ          = 190;
    localparam int  DIM_TICK_DIV    = CLK_HZ / (DIM_HZ * 256);
    localparam int  BLINK_TICK_DIV  = CLK_HZ / (24 * 256);
    // ========================================
    // Output state field encodings
    typedef enum logic [1:0] {
        LED_OFF   = 2'b00,
        LED_ON    = 2'b01,
        LED_PWM   = 2'b10,
        LED_GROUP = 2'b11
    } led_state_e;
    // Register access request from the serial front end.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] ptr;
        logic [7:0] data;
    } reg_req_s;
endpackage

// ==== hdl/led_driver_register_bank.sv ====
// Purpose: Register bank and output PWM of an eight-output LED driver.
// Assumes: The I2C front end presents one byte access per strobe, plus ack and stop pulses.
// Notes:   The oscillator is modelled by a gate on the PWM time base.
// Operation
// [R1] Pointers 00h to 11h acknowledged; 12h to 1Fh not acknowledged.
// [R2] Eighteen readable, writable registers mapped from 00h to 11h.
// [R3] First mode bits 7..5 read-only auto-increment bits, reset 1,0,0.
// [R4] First mode bit 4 set stops oscillator; reset value is set.
// [R5] Master must clear the low-power bit for proper operation.
// [R6] Oscillator runs within 500 us after low-power bit cleared.
// [R7] No dimming or blinking while oscillator is stopped.
// [R8] First mode bits 3..1 enable alternate addresses, reset zero.
// [R9] First mode bit 0 enables broadcast address, reset one.
// [R10] Second mode bits 7 and 6 read-only zero.
// [R11] Second mode bit 5 selects dimming (0) or blinking (1).
// [R12] Master keeps second mode bits 4,1 zero and bits 2,0 one.
// [R13] Second mode bit 3 picks update at STOP (0) or acknowledge (1).
// [R14] Update timing applies only to brightness and output-state registers.
// [R15] Each output has own PWM at fixed 97 kHz; here PWM_TICK_DIV truncates to 1, so at 40 MHz the PWM runs at 156.25 kHz.
// [R16] Duty equals value over 256; zero off, FFh 99.6 percent.
// [R17] Per-output duty acts only in state 10 or 11.
// [R18] All eight duty registers reset to zero.
// [R19] State field: 00 off, 01 on, 10 PWM, 11 PWM with group.
// [R20] Dimming mode combines 190 Hz group signal of group duty.
// [R21] Blinking period is (group period plus one) over 24 seconds.
// [R22] Control byte low five bits select the register accessed.
// [R23] Free-running 8-bit counter; output active while below duty.
`timescale 1ns/1ps
`default_nettype none
module led_driver_register_bank
    import led_bank_pkg::*;
#(
    parameter int NUM_LEDS    = 8,
    parameter int WAKE_COUNT  = WAKE_CYCLES
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire reg_req_s            regReq,
    input  wire logic                busAck,
    input  wire logic                busStop,
    output logic                     ptrValid,
    output logic [7:0]               rdData,
    output logic [6:0]               altAddr1,
    output logic [6:0]               altAddr2,
    output logic [6:0]               altAddr3,
    output logic [6:0]               bcastAddr,
    output logic [3:0]               addrEnable,
    output logic [2:0]               autoIncOpt,
    output logic                     oscRunning,
    output logic [NUM_LEDS-1:0]      ledOn
);
    // ========================================
    // Register storage
    logic [4:0]          modeOneLo_ff;
    logic [5:0]          modeTwoLo_ff;
    logic [7:0]          duty_ff    [NUM_LEDS];
    logic [7:0]          dutyShd_ff [NUM_LEDS];
    logic [7:0]          groupDuty_ff;
    logic [7:0]          groupPeriod_ff;
    logic [15:0]         state_ff;
    logic [15:0]         stateShd_ff;
    logic [6:0]          alt1_ff;
    logic [6:0]          alt2_ff;
    logic [6:0]          alt3_ff;
    logic [6:0]          bcast_ff;
    logic                pendShd_ff;
    logic                wrOk;
    logic                updateNow;

    // ========================================
    // Access model
    //
    // The serial front end decodes the control byte and hands
    // over one byte access per strobe.
    //
    // A write strobe lands on the next rising edge.
    //
    // A read strobe loads rdData on the next rising edge.
    //
    // rdData then holds until the next read strobe.
    //
    // Reserved pointers are refused: writes are dropped.
    //
    // Reads of reserved pointers return zero.
    //
    // Pointer stepping for auto-increment lives in the
    // front end; this bank only reports the fixed option.
    //
    // Brightness and state writes go to shadow copies.
    //
    // Reads return the shadow, so the master sees what it
    // wrote even before the outputs have changed.
    //
    // All other registers take effect on the write edge.
    //

    // Pointer check: anything past the last register is reserved.
    // [R1] Pointer acknowledge
    assign ptrValid = (regReq.ptr <= OFS_LAST_VALID);
    assign wrOk     = regReq.wr && ptrValid;

    // Mode registers; the auto-increment field is not writable here.
    // [R3] [R4] [R8] [R9] Mode one fields
    // [R10] [R11] [R13] Mode two fields
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            modeOneLo_ff <= RST_MODE_ONE_LO;
            modeTwoLo_ff <= RST_MODE_TWO_LO;
        end else if (wrOk) begin
            if (regReq.ptr == OFS_MODE_ONE) begin
                modeOneLo_ff <= regReq.data[4:0];
            end
            if (regReq.ptr == OFS_MODE_TWO) begin
                modeTwoLo_ff <= regReq.data[5:0];
            end
        end
    end

    // Global and address registers take effect immediately.
    // [R2] Register map writes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            groupDuty_ff   <= RST_GROUP_DUTY;
            groupPeriod_ff <= RST_GROUP_PERIOD;
            alt1_ff        <= RST_ALT_ONE;
            alt2_ff        <= RST_ALT_TWO;
            alt3_ff        <= RST_ALT_THREE;
            bcast_ff       <= RST_BROADCAST;
        end else if (wrOk) begin
            case (regReq.ptr)
                OFS_GROUP_DUTY:   groupDuty_ff   <= regReq.data;
                OFS_GROUP_PERIOD: groupPeriod_ff <= regReq.data;
                OFS_ALT_ONE:      alt1_ff        <= regReq.data[7:1];
                OFS_ALT_TWO:      alt2_ff        <= regReq.data[7:1];
                OFS_ALT_THREE:    alt3_ff        <= regReq.data[7:1];
                OFS_BROADCAST:    bcast_ff       <= regReq.data[7:1];
                default: begin
                end
            endcase
        end
    end

    // Brightness and state writes land in shadows and are copied to
    // the live registers at STOP or at acknowledge, so that several
    // devices on one bus can change their outputs together.
    // [R13] [R14] Deferred update
    assign updateNow = pendShd_ff &&
                       (modeTwoLo_ff[BIT_UPD_TIME] ? busAck : busStop);

    // Pending flag; a new write in the update cycle keeps it set.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pendShd_ff <= 1'b0;
        end else if (wrOk && ((regReq.ptr >= OFS_DUTY_FIRST && regReq.ptr <= OFS_DUTY_LAST) ||
                              regReq.ptr == OFS_STATE_LOW || regReq.ptr == OFS_STATE_HIGH)) begin
            pendShd_ff <= 1'b1;
        end else if (updateNow) begin
            pendShd_ff <= 1'b0;
        end
    end

    // Output-state shadow and live copy.
    // [R19] State field storage
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stateShd_ff <= {RST_STATE, RST_STATE};
            state_ff    <= {RST_STATE, RST_STATE};
        end else begin
            if (wrOk && regReq.ptr == OFS_STATE_LOW) begin
                stateShd_ff[7:0] <= regReq.data;
            end
            if (wrOk && regReq.ptr == OFS_STATE_HIGH) begin
                stateShd_ff[15:8] <= regReq.data;
            end
            if (updateNow) begin
                state_ff <= stateShd_ff;
            end
        end
    end

    // ========================================
    // Oscillator model
    //
    // The real oscillator is not modelled; its start-up is
    // a counter of WAKE_COUNT clock cycles.
    //
    // Sleeping clears the counter at once, so outputs in
    // PWM states fall to off on the next edge.
    //
    // A fully-on output does not need the oscillator and
    // stays on while the device sleeps.
    //
    // All PWM counters restart from zero on wake-up, so
    // every output starts its period in the same phase.
    //
    // The integer dividers truncate; at a 40 MHz clock the
    // per-output period is a limitation the user must know.
    //

    // ========================================
    // Time base: oscillator gate and wake-up delay
    logic        sleepBit;
    logic [$clog2(WAKE_COUNT+1)-1:0] wakeCnt_ff;
    logic [15:0] pwmDiv_ff;
    logic [7:0]  pwmCnt_ff;
    logic        pwmTick;

    assign sleepBit   = modeOneLo_ff[BIT_SLEEP];
    assign oscRunning = (wakeCnt_ff == WAKE_COUNT[$bits(wakeCnt_ff)-1:0]);

    // Wake-up counter; sleeping holds it at zero.
    // [R4] [R6] Oscillator start
    always_ff @(posedge mclk) begin
        if (!rst_n || sleepBit) begin
            wakeCnt_ff <= '0;
        end else if (!oscRunning) begin
            wakeCnt_ff <= wakeCnt_ff + 1'b1;
        end
    end

    // Per-output period counter, shared by all outputs for equal phase.
    // [R15] [R23] Free-running counter
    assign pwmTick = (pwmDiv_ff == 16'(PWM_TICK_DIV - 1));
    always_ff @(posedge mclk) begin
        if (!rst_n || !oscRunning) begin
            pwmDiv_ff <= '0;
            pwmCnt_ff <= '0;
        end else if (pwmTick) begin
            pwmDiv_ff <= '0;
            pwmCnt_ff <= pwmCnt_ff + 1'b1;
        end else begin
            pwmDiv_ff <= pwmDiv_ff + 1'b1;
        end
    end

    // ========================================
    // Group dimming or blinking generator
    logic [23:0] grpDiv_ff;
    logic [7:0]  grpCnt_ff;
    logic [23:0] grpLimit;
    logic        grpActive;

    // Blink step length scales with the period register plus one.
    // [R20] [R21] Group rate
    always_comb begin
        if (modeTwoLo_ff[BIT_GROUP_FN]) begin
            grpLimit = 24'(BLINK_TICK_DIV * (int'(groupPeriod_ff) + 1) - 1);
        end else begin
            grpLimit = 24'(DIM_TICK_DIV - 1);
        end
    end

    // [R7] Group halted asleep
    always_ff @(posedge mclk) begin
        if (!rst_n || !oscRunning) begin
            grpDiv_ff <= '0;
            grpCnt_ff <= '0;
        end else if (grpDiv_ff >= grpLimit) begin
            grpDiv_ff <= '0;
            grpCnt_ff <= grpCnt_ff + 1'b1;
        end else begin
            grpDiv_ff <= grpDiv_ff + 1'b1;
        end
    end
    assign grpActive = (grpCnt_ff < groupDuty_ff);

    // ========================================
    // Per-output duty registers and drivers
    genvar i;
    generate
        for (i = 0; i < NUM_LEDS; i++) begin : g_led
            led_state_e sel;
            logic       pwmHigh;
            assign sel = led_state_e'(state_ff[2*i+1:2*i]);
            // [R18] Duty reset zero
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    dutyShd_ff[i] <= RST_DUTY;
                    duty_ff[i]    <= RST_DUTY;
                end else begin
                    if (wrOk && regReq.ptr == 5'(OFS_DUTY_FIRST + i)) begin
                        dutyShd_ff[i] <= regReq.data;
                    end
                    if (updateNow) begin
                        duty_ff[i] <= dutyShd_ff[i];
                    end
                end
            end
            // [R16] [R23] Duty compare
            assign pwmHigh = oscRunning && (pwmCnt_ff < duty_ff[i]);
            // [R17] [R19] Output select
            always_comb begin
                case (sel)
                    LED_OFF:   ledOn[i] = 1'b0;
                    LED_ON:    ledOn[i] = 1'b1;
                    LED_PWM:   ledOn[i] = pwmHigh;
                    LED_GROUP: ledOn[i] = pwmHigh && grpActive;
                    default:   ledOn[i] = 1'b0;
                endcase
            end
        end
    endgenerate

    // ========================================
    // Read path notes
    //
    // The read mux is registered, so the read data never
    // glitches while the pointer settles.
    //
    // The auto-increment field reads as a constant.
    //
    // The top two bits of mode two always read as zero.
    //
    // Address registers read with a zero in bit 0.
    //
    // Duty registers are reached through one indexed mux
    // rather than eight case items.
    //

    // ========================================
    // Read path and address outputs
    // [R22] Pointer selects register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdData <= 8'h00;
        end else if (regReq.rd) begin
            case (regReq.ptr)
                OFS_MODE_ONE:     rdData <= {RST_AUTOINC, modeOneLo_ff};
                OFS_MODE_TWO:     rdData <= {2'b00, modeTwoLo_ff};
                OFS_GROUP_DUTY:   rdData <= groupDuty_ff;
                OFS_GROUP_PERIOD: rdData <= groupPeriod_ff;
                OFS_STATE_LOW:    rdData <= stateShd_ff[7:0];
                OFS_STATE_HIGH:   rdData <= stateShd_ff[15:8];
                OFS_ALT_ONE:      rdData <= {alt1_ff, 1'b0};
                OFS_ALT_TWO:      rdData <= {alt2_ff, 1'b0};
                OFS_ALT_THREE:    rdData <= {alt3_ff, 1'b0};
                OFS_BROADCAST:    rdData <= {bcast_ff, 1'b0};
                default: begin
                    if (regReq.ptr >= OFS_DUTY_FIRST && regReq.ptr <= OFS_DUTY_LAST) begin
                        rdData <= dutyShd_ff[3'(regReq.ptr - OFS_DUTY_FIRST)];
                    end else begin
                        rdData <= 8'h00;
                    end
                end
            endcase
        end
    end

    // Address match enables for the front end, bit order alt1..alt3, broadcast.
    // [R8] [R9] Address enables
    assign addrEnable = {modeOneLo_ff[BIT_ALT1_EN], modeOneLo_ff[BIT_ALT2_EN],
                         modeOneLo_ff[BIT_ALT3_EN], modeOneLo_ff[BIT_BCAST_EN]};
    assign autoIncOpt = RST_AUTOINC;
    assign altAddr1   = alt1_ff;
    assign altAddr2   = alt2_ff;
    assign altAddr3   = alt3_ff;
    assign bcastAddr  = bcast_ff;
endmodule
`default_nettype wire
